/* ccc_core.sv */
// Execution sequencer for subroutine call, file clear and watchdog clear
`timescale 1ns/1ps
module ccc_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Instruction words, stable from Q1 of each cycle
    input wire logic [15:0] instr_word,
    input wire logic [15:0] call_word2,
    // Live core state
    input wire logic [20:0] pc_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] bank_pointer,
    input wire logic ext_set_en,
    // Watchdog status events
    input wire logic timeout_evt,
    input wire logic sleep_evt,
    // Phase
    output logic [1:0] quarter,
    // Return stack and program counter
    output logic stack_push,
    output logic [20:0] stack_top_entry,
    output logic pc_write,
    output logic [20:0] pc_value,
    // File register access
    output logic file_read,
    output logic file_write,
    output logic [1:0] file_mode,
    output logic [7:0] file_offset,
    output logic [7:0] file_bank,
    output logic [7:0] file_data,
    output logic zero_flag_set,
    // Watchdog
    output logic dog_timer_clear,
    output logic postscaler_clear,
    output logic expiry_flag_n,
    output logic sleep_flag_n,
    // Shadow copies
    output logic [7:0] accumulator_shadow_copy,
    output logic [7:0] flag_shadow_copy,
    output logic [7:0] bank_pointer_shadow
);

    // ****************************************
    // Decode
    // ****************************************
    ccc_dec_if dif ();

    ccc_decoder u_dec (
        .word1(instr_word),
        .word2(call_word2),
        .d(dif.dec)
    );

    ccc_pkg::ccc_phase_type phase_ff;
    ccc_pkg::ccc_phase_type nxt_phase;
    logic skip_ff;
    logic op_call_ff;
    logic op_zfile_ff;
    logic op_kick_ff;
    logic save_ff;
    logic [19:0] tgt_ff;
    logic [20:0] pcb_ff;
    logic push_ff;
    logic [20:0] ret_top_ff;
    logic pc_wr_ff;
    logic [20:0] pc_val_ff;
    logic file_rd_ff;
    logic file_wr_ff;
    logic [1:0] mode_ff;
    logic [7:0] offset_ff;
    logic [7:0] bank_ff;
    logic [7:0] fdata_ff;
    logic zset_ff;
    logic dog_clr_ff;
    logic post_clr_ff;
    logic expiry_n_ff;
    logic sleep_n_ff;
    logic shadow_save_ff;

    always_comb
    begin
        case (phase_ff)
            ccc_pkg::PH_Q1: nxt_phase = ccc_pkg::PH_Q2;
            ccc_pkg::PH_Q2: nxt_phase = ccc_pkg::PH_Q3;
            ccc_pkg::PH_Q3: nxt_phase = ccc_pkg::PH_Q4;
            ccc_pkg::PH_Q4: nxt_phase = ccc_pkg::PH_Q1;
            default: nxt_phase = ccc_pkg::PH_Q1;
        endcase
    end

    wire at_q1 = phase_ff == ccc_pkg::PH_Q1;
    wire at_q2 = phase_ff == ccc_pkg::PH_Q2;
    wire at_q3 = phase_ff == ccc_pkg::PH_Q3;
    wire at_q4 = phase_ff == ccc_pkg::PH_Q4;
    // Second word of a call must never be decoded as an instruction
    wire take = at_q1 && !skip_ff;
    wire take_call = take && dif.is_call;
    wire take_zfile = take && dif.is_zfile;
    wire take_kick = take && dif.is_kick;

    // ****************************************
    // Address mode selection
    // ****************************************
    wire idx_mode = !dif.bank_sel && ext_set_en && (dif.file_addr <= ccc_pkg::INDEX_LIMIT);
    wire [1:0] sel_mode = dif.bank_sel ? ccc_pkg::MODE_BANKED :
        (idx_mode ? ccc_pkg::MODE_INDEXED : ccc_pkg::MODE_ACCESS);
    wire [7:0] sel_bank = dif.bank_sel ? bank_pointer : 8'h00;

    // ****************************************
    // Next values
    // ****************************************
    wire nxt_skip = (at_q4 && op_call_ff) ? 1'b1 : (at_q1 ? 1'b0 : skip_ff);
    wire nxt_op_call = at_q1 ? take_call : op_call_ff;
    wire nxt_op_zfile = at_q1 ? take_zfile : op_zfile_ff;
    wire nxt_op_kick = at_q1 ? take_kick : op_kick_ff;
    wire nxt_push = at_q2 && op_call_ff;
    wire nxt_shadow_save = at_q2 && op_call_ff && save_ff;
    wire nxt_pc_wr = at_q3 && op_call_ff;
    wire nxt_file_rd = take_zfile;
    wire nxt_file_wr = at_q3 && op_zfile_ff;
    wire nxt_kick = at_q3 && op_kick_ff;
    // Watchdog clear wins over a same-quarter status event
    wire nxt_expiry_n = nxt_kick ? 1'b1 : (timeout_evt ? 1'b0 : expiry_n_ff);
    wire nxt_sleep_n = nxt_kick ? 1'b1 : (sleep_evt ? 1'b0 : sleep_n_ff);

    // ****************************************
    // Sequencer and decoded operation
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_ff <= ccc_pkg::PH_Q1;
            skip_ff <= 1'b0;
            op_call_ff <= 1'b0;
            op_zfile_ff <= 1'b0;
            op_kick_ff <= 1'b0;
            save_ff <= 1'b0;
            tgt_ff <= 20'h00000;
            pcb_ff <= ccc_pkg::PC_RESET;
        end
        else
        begin
            phase_ff <= nxt_phase;
            skip_ff <= nxt_skip;
            op_call_ff <= nxt_op_call;
            op_zfile_ff <= nxt_op_zfile;
            op_kick_ff <= nxt_op_kick;
            if (take_call)
            begin
                save_ff <= dif.save_ctx;
                tgt_ff <= dif.target;
                pcb_ff <= pc_in;
            end
        end
    end

    // ****************************************
    // Stack, counter and file strobes
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            push_ff <= 1'b0;
            ret_top_ff <= ccc_pkg::PC_RESET;
            pc_wr_ff <= 1'b0;
            pc_val_ff <= ccc_pkg::PC_RESET;
            shadow_save_ff <= 1'b0;
            file_rd_ff <= 1'b0;
            file_wr_ff <= 1'b0;
            zset_ff <= 1'b0;
            fdata_ff <= ccc_pkg::CLEAR_VALUE;
        end
        else
        begin
            push_ff <= nxt_push;
            pc_wr_ff <= nxt_pc_wr;
            shadow_save_ff <= nxt_shadow_save;
            file_rd_ff <= nxt_file_rd;
            file_wr_ff <= nxt_file_wr;
            zset_ff <= nxt_file_wr;
            fdata_ff <= ccc_pkg::CLEAR_VALUE;
            if (nxt_push)
                ret_top_ff <= pcb_ff + ccc_pkg::RET_OFFSET;
            if (nxt_pc_wr)
                pc_val_ff <= {tgt_ff, 1'b0};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_ff <= ccc_pkg::MODE_ACCESS;
            offset_ff <= 8'h00;
            bank_ff <= 8'h00;
        end
        else if (take_zfile)
        begin
            mode_ff <= sel_mode;
            offset_ff <= dif.file_addr;
            bank_ff <= sel_bank;
        end
    end

    // ****************************************
    // Watchdog clear and status flags
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dog_clr_ff <= 1'b0;
            post_clr_ff <= 1'b0;
            expiry_n_ff <= ccc_pkg::FLAG_N_RESET;
            sleep_n_ff <= ccc_pkg::FLAG_N_RESET;
        end
        else
        begin
            dog_clr_ff <= nxt_kick;
            post_clr_ff <= nxt_kick;
            expiry_n_ff <= nxt_expiry_n;
            sleep_n_ff <= nxt_sleep_n;
        end
    end

    ccc_shadow u_shadow (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .save(shadow_save_ff),
        .acc_in(acc_in),
        .flags_in(flags_in),
        .bank_in(bank_pointer),
        .accumulator_shadow_copy(accumulator_shadow_copy),
        .flag_shadow_copy(flag_shadow_copy),
        .bank_pointer_shadow(bank_pointer_shadow)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign quarter = phase_ff;
    assign stack_push = push_ff;
    assign stack_top_entry = ret_top_ff;
    assign pc_write = pc_wr_ff;
    assign pc_value = pc_val_ff;
    assign file_read = file_rd_ff;
    assign file_write = file_wr_ff;
    assign file_mode = mode_ff;
    assign file_offset = offset_ff;
    assign file_bank = bank_ff;
    assign file_data = fdata_ff;
    assign zero_flag_set = zset_ff;
    assign dog_timer_clear = dog_clr_ff;
    assign postscaler_clear = post_clr_ff;
    assign expiry_flag_n = expiry_n_ff;
    assign sleep_flag_n = sleep_n_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_push_return_addr: assert property (
        push_ff |-> ret_top_ff == pcb_ff + ccc_pkg::RET_OFFSET)
        else $error("pushed address is not instruction start plus four");
    a_shadow_saved: assert property (shadow_save_ff |=>
        accumulator_shadow_copy == $past(acc_in) && flag_shadow_copy == $past(flags_in)
        && bank_pointer_shadow == $past(bank_pointer))
        else $error("shadow copies not taken on save");
    a_shadow_kept: assert property (!shadow_save_ff |=>
        $stable(accumulator_shadow_copy) && $stable(flag_shadow_copy)
        && $stable(bank_pointer_shadow))
        else $error("shadow copies changed without save");
    a_pc_target: assert property (pc_wr_ff |-> pc_val_ff == {tgt_ff, 1'b0} && at_q4)
        else $error("counter not loaded with target in Q4");
    a_call_idle: assert property (pc_wr_ff |=>
        (!push_ff && !file_rd_ff && !file_wr_ff && !dog_clr_ff && !pc_wr_ff)[*4])
        else $error("second call cycle not idle");
    a_call_decode: assert property (take_call |-> ##2 push_ff ##1 pc_wr_ff)
        else $error("call not sequenced push then counter write");
    a_zfile_result: assert property (file_wr_ff |->
        zero_flag_set && file_data == ccc_pkg::CLEAR_VALUE && $past(file_rd_ff, 2))
        else $error("clear did not write zero with zero flag");
    a_zfile_sequence: assert property (
        take_zfile |-> ##1 file_rd_ff ##1 !file_wr_ff ##1 file_wr_ff)
        else $error("clear read/write quarters wrong");
    a_zfile_mode: assert property (take_zfile |=>
        (file_mode == ccc_pkg::MODE_BANKED) == $past(dif.bank_sel)
        && (file_mode != ccc_pkg::MODE_INDEXED || $past(ext_set_en)))
        else $error("clear address mode wrong");
    a_clear_bank: assert property (take_zfile |=>
        file_bank == ($past(dif.bank_sel) ? $past(bank_pointer) : 8'h00))
        else $error("clear bank select wrong");
    a_index_mode: assert property (take_zfile && !dif.bank_sel && ext_set_en
        && dif.file_addr <= ccc_pkg::INDEX_LIMIT |=> file_mode == ccc_pkg::MODE_INDEXED)
        else $error("indexed mode not used");
    a_kick_clear: assert property (take_kick |-> ##3
        (dog_clr_ff && post_clr_ff && expiry_flag_n && sleep_flag_n) ##1 !dog_clr_ff)
        else $error("watchdog clear not completed within cycle");
    a_kick_flags: assert property (dog_clr_ff |->
        postscaler_clear && expiry_flag_n && sleep_flag_n)
        else $error("postscaler or status flags not set on clear");

    c_call_save: cover property (take_call && dif.save_ctx ##3 pc_wr_ff);
    c_zfile_indexed: cover property (take_zfile && idx_mode ##3 file_wr_ff);
    c_kick: cover property (take_kick ##3 dog_clr_ff);
    c_call_plain: cover property (take_call && !dif.save_ctx ##2 push_ff);

endmodule

/* ccc_pkg.sv */
// Constants and types shared by the call, clear-register and watchdog-clear logic
// Summary of operation
// - Call pushes instruction address plus four
// - Save bit set copies accumulator, flags, bank
// - Save bit clear leaves shadow copies alone
// - Call target literal loads counter bits 20:1
// - Call takes two cycles, second one idle
// - Call recognised by 1110110 then 1111 word
// - Clear writes zero and sets zero flag
// - Clear recognised by 0110101, bank bit, address
// - Bank bit zero access bank, one banked
// - Bank zero, extended, address <=95 uses indexed
// - Opcode 0004 resets watchdog counter in cycle
// - Watchdog clear also resets the postscaler
// - Watchdog clear sets both low-active status flags
package ccc_pkg;

    // ****************************************
    // Opcode patterns
    // ****************************************
    localparam logic [15:0] OPC_MASK7 = 16'hFE00;
    localparam logic [15:0] CALL_OPC = 16'hEC00;
    localparam logic [15:0] ZERO_FILE_OPC = 16'h6A00;
    localparam logic [15:0] WORD2_MASK = 16'hF000;
    localparam logic [15:0] WORD2_OPC = 16'hF000;
    localparam logic [15:0] KICK_OPC = 16'h0004;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SAVE_BIT = 8;
    localparam int BANK_BIT = 8;

    // ****************************************
    // Values and offsets
    // ****************************************
    localparam logic [20:0] RET_OFFSET = 21'h000004;
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;
    localparam logic FLAG_N_RESET = 1'h1;
    localparam logic [7:0] SHADOW_RESET = 8'h00;
    localparam logic [20:0] PC_RESET = 21'h000000;

    // ****************************************
    // Address modes of the file access
    // ****************************************
    localparam logic [1:0] MODE_ACCESS = 2'h0;
    localparam logic [1:0] MODE_BANKED = 2'h1;
    localparam logic [1:0] MODE_INDEXED = 2'h2;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} ccc_phase_type;

endpackage

/* ccc_dec_if.sv */
// Decoded instruction fields passed from the decoder to the core
`timescale 1ns/1ps
interface ccc_dec_if;
    logic is_call;
    logic is_zfile;
    logic is_kick;
    logic save_ctx;
    logic bank_sel;
    logic [19:0] target;
    logic [7:0] file_addr;

    modport dec (output is_call, is_zfile, is_kick, save_ctx, bank_sel, target, file_addr);
    modport core (input is_call, is_zfile, is_kick, save_ctx, bank_sel, target, file_addr);
endinterface

/* ccc_decoder.sv */
// Combinational decode of the three supported instructions
`timescale 1ns/1ps
module ccc_decoder (
    // Instruction words
    input wire logic [15:0] word1,
    input wire logic [15:0] word2,
    // Decoded fields
    ccc_dec_if.dec d
);
    wire call_hit = (word1 & ccc_pkg::OPC_MASK7) == ccc_pkg::CALL_OPC;
    wire word2_hit = (word2 & ccc_pkg::WORD2_MASK) == ccc_pkg::WORD2_OPC;

    assign d.is_call = call_hit && word2_hit;
    assign d.is_zfile = (word1 & ccc_pkg::OPC_MASK7) == ccc_pkg::ZERO_FILE_OPC;
    assign d.is_kick = word1 == ccc_pkg::KICK_OPC;
    assign d.save_ctx = word1[ccc_pkg::SAVE_BIT];
    assign d.bank_sel = word1[ccc_pkg::BANK_BIT];
    assign d.target = {word2[11:0], word1[7:0]};
    assign d.file_addr = word1[7:0];
endmodule

/* ccc_shadow.sv */
// Shadow copies of accumulator, flag register and bank pointer
`timescale 1ns/1ps
module ccc_shadow (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Save request and live values
    input wire logic save,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] bank_in,
    // Shadow copies
    output logic [7:0] accumulator_shadow_copy,
    output logic [7:0] flag_shadow_copy,
    output logic [7:0] bank_pointer_shadow
);
    logic [7:0] acc_sh_ff;
    logic [7:0] flag_sh_ff;
    logic [7:0] bank_sh_ff;

    // Hold unless a save is requested
    wire [7:0] nxt_acc_sh = save ? acc_in : acc_sh_ff;
    wire [7:0] nxt_flag_sh = save ? flags_in : flag_sh_ff;
    wire [7:0] nxt_bank_sh = save ? bank_in : bank_sh_ff;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_sh_ff <= ccc_pkg::SHADOW_RESET;
            flag_sh_ff <= ccc_pkg::SHADOW_RESET;
            bank_sh_ff <= ccc_pkg::SHADOW_RESET;
        end
        else
        begin
            acc_sh_ff <= nxt_acc_sh;
            flag_sh_ff <= nxt_flag_sh;
            bank_sh_ff <= nxt_bank_sh;
        end
    end

    assign accumulator_shadow_copy = acc_sh_ff;
    assign flag_shadow_copy = flag_sh_ff;
    assign bank_pointer_shadow = bank_sh_ff;
endmodule

/* tb_top.sv */
// Self-checking bench for the call, file-clear and watchdog-clear sequencer
`timescale 1ns/1ps
module tb_top;
    // ****************************************
    // Signals
    // ****************************************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [15:0] call_word2 = 16'h0000;
    logic [20:0] pc_in = 21'h000000;
    logic [7:0] acc_in = 8'h00;
    logic [7:0] flags_in = 8'h00;
    logic [7:0] bank_pointer = 8'h00;
    logic ext_set_en = 1'b0;
    logic timeout_evt = 1'b0;
    logic sleep_evt = 1'b0;
    logic [1:0] quarter;
    logic stack_push, pc_write, file_read, file_write, zero_flag_set;
    logic [20:0] stack_top_entry, pc_value;
    logic [1:0] file_mode;
    logic [7:0] file_offset, file_bank, file_data;
    logic dog_timer_clear, postscaler_clear, expiry_flag_n, sleep_flag_n;
    logic [7:0] accumulator_shadow_copy, flag_shadow_copy, bank_pointer_shadow;
    logic [3:1] c_push, c_pcw, c_rd, c_wr, c_zf, c_dog, c_post;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    ccc_core dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word), .call_word2(call_word2),
        .pc_in(pc_in), .acc_in(acc_in), .flags_in(flags_in), .bank_pointer(bank_pointer),
        .ext_set_en(ext_set_en), .timeout_evt(timeout_evt), .sleep_evt(sleep_evt),
        .quarter(quarter), .stack_push(stack_push), .stack_top_entry(stack_top_entry),
        .pc_write(pc_write), .pc_value(pc_value), .file_read(file_read),
        .file_write(file_write), .file_mode(file_mode), .file_offset(file_offset),
        .file_bank(file_bank), .file_data(file_data), .zero_flag_set(zero_flag_set),
        .dog_timer_clear(dog_timer_clear), .postscaler_clear(postscaler_clear),
        .expiry_flag_n(expiry_flag_n), .sleep_flag_n(sleep_flag_n),
        .accumulator_shadow_copy(accumulator_shadow_copy),
        .flag_shadow_copy(flag_shadow_copy), .bank_pointer_shadow(bank_pointer_shadow)
    );

    // ****************************************
    // Clock, timeout and common tasks
    // ****************************************
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Whole run needs under a hundred cycles; generous ceiling
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares = miscompares + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Records strobes in Q2, Q3 and Q4 of the cycle just decoded
    task automatic capture();
        for (int k = 1; k <= 3; k++)
        begin
            @(negedge sys_clk);
            if (k == 1)
            begin
                instr_word = 16'h0000;
                call_word2 = 16'h0000;
            end
            c_push[k] = stack_push;
            c_pcw[k] = pc_write;
            c_rd[k] = file_read;
            c_wr[k] = file_write;
            c_zf[k] = zero_flag_set;
            c_dog[k] = dog_timer_clear;
            c_post[k] = postscaler_clear;
        end
    endtask

    // Words are presented during Q1 only, then replaced by a no-op
    task automatic issue(input logic [15:0] w1, input logic [15:0] w2);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (quarter !== 2'h0 && n < 16)
        begin
            @(negedge sys_clk);
            n++;
        end
        instr_word = w1;
        call_word2 = w2;
        capture();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_call_save();
        pc_in = 21'h012340;
        acc_in = 8'hA5;
        flags_in = 8'h3C;
        bank_pointer = 8'h07;
        issue(16'hED5A, 16'hF9BC);
        check(c_push, 3'b010);
        check(c_pcw, 3'b100);
        check(stack_top_entry, 21'h012344);
        check(pc_value, {20'h9BC5A, 1'b0});
        check(accumulator_shadow_copy, 8'hA5);
        check(flag_shadow_copy, 8'h3C);
        check(bank_pointer_shadow, 8'h07);
        // A clear offered in the idle cycle must be dropped
        issue(16'h6AFF, 16'h0000);
        check(c_rd, 3'b000);
        check(c_wr, 3'b000);
    endtask

    task automatic test_call_nosave();
        pc_in = 21'h0FFFFC;
        acc_in = 8'h11;
        flags_in = 8'h22;
        bank_pointer = 8'h33;
        issue(16'hEC01, 16'hF000);
        check(c_push, 3'b010);
        check(stack_top_entry, 21'h100000);
        check(pc_value, 21'h000002);
        check(accumulator_shadow_copy, 8'hA5);
        check(flag_shadow_copy, 8'h3C);
        check(bank_pointer_shadow, 8'h07);
        issue(16'h0000, 16'h0000);
        // Second word without its 1111 prefix: no call at all
        issue(16'hED22, 16'hE123);
        check(c_push, 3'b000);
        check(c_pcw, 3'b000);
        check(accumulator_shadow_copy, 8'hA5);
    endtask

    task automatic clear_case(input logic a, input logic ext, input logic [7:0] f,
                              input logic [1:0] mode, input logic [7:0] bank);
        ext_set_en = ext;
        issue({7'b0110101, a, f}, 16'h0000);
        check(c_rd, 3'b001);
        check(c_wr, 3'b100);
        check(c_zf, 3'b100);
        check(file_data, 8'h00);
        check(file_offset, f);
        check(file_mode, mode);
        check(file_bank, bank);
    endtask

    task automatic test_clear();
        bank_pointer = 8'h0D;
        clear_case(1'b1, 1'b1, 8'h20, ccc_pkg::MODE_BANKED, 8'h0D);
        clear_case(1'b0, 1'b0, 8'h10, ccc_pkg::MODE_ACCESS, 8'h00);
        clear_case(1'b0, 1'b1, 8'h5F, ccc_pkg::MODE_INDEXED, 8'h00);
        clear_case(1'b0, 1'b1, 8'h60, ccc_pkg::MODE_ACCESS, 8'h00);
        clear_case(1'b1, 1'b0, 8'hFF, ccc_pkg::MODE_BANKED, 8'h0D);
    endtask

    task automatic test_kick();
        @(negedge sys_clk);
        timeout_evt = 1'b1;
        sleep_evt = 1'b1;
        @(negedge sys_clk);
        timeout_evt = 1'b0;
        sleep_evt = 1'b0;
        @(negedge sys_clk);
        check(expiry_flag_n, 1'b0);
        check(sleep_flag_n, 1'b0);
        // Neighbouring opcode must not touch the watchdog
        issue(16'h0005, 16'h0000);
        check(c_dog, 3'b000);
        check(expiry_flag_n, 1'b0);
        issue(16'h0004, 16'h0000);
        check(c_dog, 3'b100);
        check(c_post, 3'b100);
        check(expiry_flag_n, 1'b1);
        check(sleep_flag_n, 1'b1);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (20) @(negedge sys_clk);
        check(quarter, 2'h0);
        check(expiry_flag_n, 1'b1);
        check(accumulator_shadow_copy, 8'h00);
        rst_n = 1'b1;
        test_call_save();
        test_call_nosave();
        test_clear();
        test_kick();
        end_of_test();
    end
endmodule
